// [mabi_pkg.sv]
// package for the host-side converter bus controller
// assumes a 20 MHz ref_clk; all times derived from it
package mabi_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 2000;      // conversion_time, typical
  localparam int CONV_MARGIN_NS = 600;     // guard beyond typical
  localparam int RECOVERY_TIME_NS = 500;   // recovery_time
  localparam int READ_GAP_NS = 2500;       // least gap between reads, mode 1
  localparam int STROBE_NS = 150;          // read strobe low time, mode 1
  // least times round up
  localparam int RECOVERY_CYC =
    (RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_GAP_CYC =
    (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest wait for ready before giving up
  localparam int TIMEOUT_CYC =
    (CONV_TIME_NS + CONV_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;
  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_SETUP  = 6'b000010,
    ST_WAITRD = 6'b000100,
    ST_STROBE = 6'b001000,
    ST_END    = 6'b010000,
    ST_GAP    = 6'b100000
  } mabi_state_e;
endpackage : mabi_pkg

// [mabi_sync.sv]
// three-stage synchroniser for pin inputs
// assumes input is asynchronous to clk; output changes once stages agree
`timescale 1ns/1ps
module mabi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, filtered out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  // ****************************************
  // shift chain; s1 only feeds s2 (metastability)
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // accept a new level only when second and third agree, per bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r <= INIT;
    end else begin
      q_r <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
    end
  end
  assign pin_out = q_r;
endmodule : mabi_sync

// [mabi_host.sv]
// host controller that drives the multichannel converter bus pins
// assumes converter pins wired directly; ready is open drain with pull-up
`timescale 1ns/1ps
module mabi_host
  import mabi_pkg::*;
#(
  parameter int CHAN_W = 3,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  input wire logic req_wait_mode,
  input wire logic [CHAN_W-1:0] req_chan,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_timeout,
  // converter pins
  output logic cs_n,
  output logic rd_n,
  output logic [CHAN_W-1:0] chan_sel,
  input wire logic [DATA_W-1:0] result_bus,
  input wire logic int_n,
  input wire logic rdy_n
);
  mabi_state_e state_r;
  mabi_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic mode_r;
  logic [DATA_W-1:0] data_s;
  logic int_n_s;
  logic rdy_s;
  logic rdy_seen_r;
  logic done_s;

  // ****************************************
  // pin synchronisers
  // ****************************************
  mabi_sync #(.W(DATA_W + 2), .INIT({{DATA_W{1'b0}}, 2'b11})) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pin_in({result_bus, int_n, rdy_n}),
    .pin_out({data_s, int_n_s, rdy_s})
  );

  // wait mode ends when ready, once seen low, is released and done is low;
  // done alone is not enough: after a pipelined read it stays low
  assign done_s = rdy_seen_r & rdy_s & ~int_n_s;
  assign req_ready = (state_r == ST_IDLE);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (req_valid) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // address settles with select low one cycle before strobe
        state_nxt = mode_r ? ST_WAITRD : ST_STROBE;
      end
      ST_WAITRD: begin
        // ready low first; wait till it is released and done is low
        if (done_s || cnt_r == CNT_W'(TIMEOUT_CYC)) begin
          state_nxt = ST_END;
        end
      end
      ST_STROBE: begin
        if (cnt_r == CNT_W'(STROBE_CYC)) begin
          state_nxt = ST_END;
        end
      end
      ST_END: begin
        state_nxt = ST_GAP;
      end
      ST_GAP: begin
        // recovery in wait mode, read spacing in pipelined mode
        if (mode_r ? (cnt_r >= CNT_W'(RECOVERY_CYC))
                   : (cnt_r >= CNT_W'(READ_GAP_CYC))) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycle counter restarts on each state change
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (cnt_r != '1) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // the sync chain still shows released ready for a few cycles after
  // select falls, so a release only counts once the low level came through
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdy_seen_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      rdy_seen_r <= 1'b0;
    end else if (state_r == ST_WAITRD && !rdy_s) begin
      rdy_seen_r <= 1'b1;
    end
  end

  // ****************************************
  // request capture
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_r <= 1'b0;
    end else if (state_r == ST_IDLE && req_valid) begin
      mode_r <= req_wait_mode;
    end
  end

  // ****************************************
  // pin drive: select wraps strobe so device never sees lone strobe
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      chan_sel <= CHAN_W'(CHAN_RST);
    end else begin
      cs_n <= ~(state_nxt inside {ST_SETUP, ST_WAITRD, ST_STROBE});
      rd_n <= ~(state_nxt inside {ST_WAITRD, ST_STROBE});
      // address comes straight from the request so it stands with select
      if (state_r == ST_IDLE && req_valid) begin
        chan_sel <= req_chan;
      end
    end
  end

  // ****************************************
  // answer: sample data while strobe still low (floats afterwards)
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= DATA_W'(RESULT_RST);
      rsp_timeout <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_r == ST_END) begin
        rsp_valid <= 1'b1;
        rsp_data <= data_s;
        rsp_timeout <= mode_r & ~done_s;
      end
    end
  end
endmodule : mabi_host

// [mabi_adc_model.sv]
// behavioural model of the converter seen from its bus pins
// assumes ref_clk timing; ready has a pull-up, so released reads 1
`timescale 1ns/1ps
module mabi_adc_model (
  // clock, reset, pace
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] conv_cyc,
  // bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [2:0] chan_sel,
  output logic [7:0] result_bus,
  output logic int_n,
  output logic rdy_n
);
  logic [7:0] out_r, cnt_r;
  logic [2:0] ch_r;
  logic busy_r, act_q, rel_r;
  wire act = !cs_n && !rd_n;
  // conversion pacing and done flag
  always_ff @(posedge ref_clk) begin
    act_q <= act;
    if (!rst_n) begin
      busy_r <= 1'b0;
      int_n <= 1'b1;
      rel_r <= 1'b0;
      out_r <= 8'h00;
      cnt_r <= 8'h00;
    end else begin
      if (act && !act_q) begin
        busy_r <= 1'b1;
        cnt_r <= 8'h00;
        ch_r <= chan_sel;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == 8'h14) out_r[7:4] <= {1'b1, ch_r};
        if (cnt_r == conv_cyc) begin
          busy_r <= 1'b0;
          int_n <= 1'b0;
          rel_r <= 1'b1;
          out_r <= {1'b1, ch_r, 1'b0, ch_r};
        end
      end
      if (!act && act_q) int_n <= 1'b1;
      if (cs_n) rel_r <= 1'b0;
    end
  end
  // old data early in a read; a floating bus shows the inverse, not a hold
  assign result_bus = (act && (!busy_r || cnt_r < 8'h08)) ?
    out_r : ~out_r;
  // ready low from select falling until the conversion ends or select rises
  assign rdy_n = cs_n || rel_r;
endmodule : mabi_adc_model

// [mabi_monitor.sv]
// checker on the controller's ports
// assumes bind onto mabi_host; sync active-low reset
`timescale 1ns/1ps
module mabi_monitor #(
  parameter int CHAN_W = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // user side
  input wire logic req_valid,
  input wire logic [CHAN_W-1:0] req_chan,
  input wire logic req_ready,
  input wire logic rsp_valid,
  // pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [CHAN_W-1:0] chan_sel
);
  logic [7:0] gap_r, low_r;
  logic short_r;
  logic [CHAN_W-1:0] chan_r;
  // saturating counts so a long idle never wraps into a false gap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) gap_r <= 8'hFF;
    else if (!rd_n) gap_r <= 8'h00;
    else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
  end
  // strobe length tells the mode of the last read
  always_ff @(posedge ref_clk) begin
    if (!rst_n || rd_n) low_r <= 8'h00;
    else if (low_r != 8'hFF) low_r <= low_r + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) short_r <= 1'b0;
    else if (rd_n && low_r != 8'h00) short_r <= low_r < 8'h09;
  end
  always_ff @(posedge ref_clk) begin
    if (req_valid && req_ready) chan_r <= req_chan;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_open; $fell(cs_n) ##[1:2] $fell(rd_n); endsequence
  chk_rd_in_cs: assert property (!rd_n |-> !cs_n)
    else $error("strobe without select");
  chk_strobe_min: assert property ($fell(rd_n) |-> !rd_n[*3])
    else $error("strobe too short");
  chk_start_seq: assert property (s_take |-> ##[1:2] s_open)
    else $error("read not opened");
  chk_chan_held: assert property (!cs_n |-> chan_sel == chan_r)
    else $error("channel pins wrong");
  chk_read_gap: assert property (
    $fell(rd_n) && short_r |-> gap_r >= 8'h32)
    else $error("reads too close");
  chk_recovery: assert property ($fell(rd_n) |-> gap_r >= 8'h0A)
    else $error("no recovery time");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer too long");
  chk_busy_ready: assert property (!cs_n |-> !req_ready)
    else $error("ready while busy");
endmodule : mabi_monitor
bind mabi_host mabi_monitor #(.CHAN_W(CHAN_W)) mabi_monitor_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
  .req_chan(req_chan), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .cs_n(cs_n), .rd_n(rd_n), .chan_sel(chan_sel));

// [testbench.sv]
// self-checking bench for the converter bus controller
// assumes the converter model on the pins
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst_n, req_valid, req_wait_mode, req_ready;
  logic rsp_valid, rsp_timeout, cs_n, rd_n, int_n, rdy_n;
  logic [2:0] req_chan, chan_sel;
  logic [7:0] rsp_data, result_bus, conv_cyc;
  int errors = 0, total_checks = 0, cycles = 0;
  mabi_host mabi_host_inst (.ref_clk, .rst_n, .req_valid, .req_wait_mode,
    .req_chan, .req_ready, .rsp_valid, .rsp_data, .rsp_timeout, .cs_n,
    .rd_n, .chan_sel, .result_bus, .int_n, .rdy_n);
  mabi_adc_model mabi_adc_model_inst (.ref_clk, .rst_n, .conv_cyc, .cs_n,
    .rd_n, .chan_sel, .result_bus, .int_n, .rdy_n);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  function automatic logic [7:0] code(input logic [2:0] c);
    return {1'b1, c, 1'b0, c};
  endfunction : code
  // one request, held until taken, then wait for the answer
  task run(input logic w, input logic [2:0] c);
    int n;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_wait_mode = w;
    req_chan = c;
    n = 0;
    // ready follows state only, so it is settled at the falling edge
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      errors++;
      finish_test();
    end
    // taken at the rising edge between these two falling edges
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      errors++;
      finish_test();
    end
  endtask : run
  task test_wait_all;
    for (int i = 0; i < 8; i++) begin
      run(1'b1, 3'(i));
      check(rsp_data, code(3'(i)));
      check({7'h00, rsp_timeout}, 8'h00);
    end
  endtask : test_wait_all
  // pipelined reads hand back the conversion before, across a mode switch
  task test_pipe;
    run(1'b0, 3'h2);
    check(rsp_data, code(3'h7));
    run(1'b0, 3'h5);
    check(rsp_data, code(3'h2));
    run(1'b1, 3'h0);
    check(rsp_data, code(3'h0));
    run(1'b0, 3'h6);
    check(rsp_data, code(3'h0));
  endtask : test_pipe
  // a converter slower than the guard forces the give-up path
  task test_slow;
    conv_cyc = 8'h46;
    run(1'b1, 3'h3);
    check({7'h00, rsp_timeout}, 8'h01);
  endtask : test_slow
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_wait_mode = 1'b0;
    req_chan = 3'h0;
    conv_cyc = 8'h28;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    test_wait_all();
    test_pipe();
    test_slow();
    finish_test();
  end
endmodule : testbench
